// File: verilog/sfc_core.sv
// module: stack fault flags, fast context shadow, computed jump and table read
// Overview of operation
// - enabled fault sets flag then resets device
// - disabled fault sets flag, no reset
// - flags clear only by software or power-on
// - one-level hidden shadow of three registers
// - every interrupt vector captures the three registers
// - fast interrupt return restores shadow contents
// - high priority capture overwrites low priority values
// - fast call saves registers with the push
// - fast return restores registers while popping
// - adding working to program counter advances bytes
// - literal return loads working register, returns
// - table read fetches one byte per operation
// - both word bytes addressable by table pointer
`timescale 1ns/10ps
`default_nettype none
module sfc_core (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_stack_fault_reset_enable,
  input wire logic i_stack_full_evt,
  input wire logic i_stack_underflow_evt,
  input wire logic i_flag_wr,
  input wire logic i_stack_full_wr_val,
  input wire logic i_stack_underflow_wr_val,
  input wire sfc_pkg::sfc_op_t i_op,
  input wire sfc_pkg::sfc_ctx_t i_ctx,
  input wire logic [sfc_pkg::DATA_W-1:0] i_literal,
  input wire logic [sfc_pkg::PC_W-1:0] i_program_counter,
  input wire logic [sfc_pkg::TP_W-1:0] i_table_pointer,
  input wire logic [15:0] i_word_data,
  output logic o_stack_full_flag,
  output logic o_stack_underflow_flag,
  output logic o_device_reset,
  output sfc_pkg::sfc_ctx_t o_ctx_restore,
  output logic o_ctx_restore_valid,
  output logic [sfc_pkg::DATA_W-1:0] o_working_load,
  output logic o_working_load_valid,
  output logic [sfc_pkg::PC_W-1:0] o_pc_jump,
  output logic o_pc_jump_valid,
  output logic [sfc_pkg::TP_W-2:0] o_word_addr,
  output logic o_word_req,
  output logic [sfc_pkg::DATA_W-1:0] o_table_latch,
  output logic o_table_done
);
  sfc_pkg::sfc_ctx_t shadow_q;
  logic fault_pend_q;

  function automatic logic [sfc_pkg::PC_W-1:0] add_offset(
    input logic [sfc_pkg::PC_W-1:0] pc, input logic [sfc_pkg::DATA_W-1:0] off);
    add_offset = pc + {{(sfc_pkg::PC_W-sfc_pkg::DATA_W){1'b0}}, off};
  endfunction : add_offset

  // flags: event set wins over software clear; power-on clears
  always_ff @(posedge i_mclk) begin
    if (i_rst && i_por) begin
      o_stack_full_flag <= 1'b0;
      o_stack_underflow_flag <= 1'b0;
    end else begin
      if (i_stack_full_evt)
        o_stack_full_flag <= 1'b1;
      else if (i_flag_wr)
        o_stack_full_flag <= i_stack_full_wr_val;
      if (i_stack_underflow_evt)
        o_stack_underflow_flag <= 1'b1;
      else if (i_flag_wr)
        o_stack_underflow_flag <= i_stack_underflow_wr_val;
    end
  end

  // reset follows the flag by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fault_pend_q <= 1'b0;
      o_device_reset <= 1'b0;
    end else begin
      fault_pend_q <= i_stack_fault_reset_enable &&
                      (i_stack_full_evt || i_stack_underflow_evt);
      o_device_reset <= fault_pend_q;
    end
  end

  // hidden shadow store, no software port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shadow_q <= sfc_pkg::CTX_RESET;
    end else if (i_op.int_vector || i_op.fast_call) begin
      shadow_q <= i_ctx;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ctx_restore <= sfc_pkg::CTX_RESET;
      o_ctx_restore_valid <= 1'b0;
    end else begin
      o_ctx_restore_valid <= i_op.fast_return_from_interrupt_instr || i_op.fast_ret;
      if (i_op.fast_return_from_interrupt_instr || i_op.fast_ret)
        o_ctx_restore <= shadow_q;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_working_load <= sfc_pkg::BYTE_ZERO;
      o_working_load_valid <= 1'b0;
      o_pc_jump <= sfc_pkg::PC_RESET;
      o_pc_jump_valid <= 1'b0;
    end else begin
      o_working_load_valid <= i_op.ret_literal;
      if (i_op.ret_literal)
        o_working_load <= i_literal;
      o_pc_jump_valid <= i_op.add_pcl;
      if (i_op.add_pcl)
        o_pc_jump <= add_offset(i_program_counter, i_ctx.working);
    end
  end

  sfc_table_reader u_tbl (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_start(i_op.tbl_read),
    .i_table_pointer(i_table_pointer),
    .o_word_addr(o_word_addr),
    .o_word_req(o_word_req),
    .i_word_data(i_word_data),
    .o_table_latch(o_table_latch),
    .o_done(o_table_done)
  );

  sequence s_fault;
    i_stack_fault_reset_enable && (i_stack_full_evt || i_stack_underflow_evt);
  endsequence

  property p_fault_reset;
    @(posedge i_mclk) disable iff (i_rst) s_fault |=> ##1 o_device_reset;
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("no reset after fault");

  property p_no_reset;
    @(posedge i_mclk) disable iff (i_rst)
      !i_stack_fault_reset_enable |=> ##1 !o_device_reset;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("reset without enable");

  property p_flag_set;
    @(posedge i_mclk) disable iff (i_rst) i_stack_full_evt |=> o_stack_full_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("full flag not set");

  property p_flag_hold;
    @(posedge i_mclk) disable iff (i_rst)
      o_stack_underflow_flag && !i_flag_wr |=> o_stack_underflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("underflow flag lost");

  property p_capture;
    @(posedge i_mclk) disable iff (i_rst)
      i_op.int_vector || i_op.fast_call |=> shadow_q == $past(i_ctx);
  endproperty
  a_capture: assert property (p_capture) else $error("shadow not captured");

  property p_restore;
    @(posedge i_mclk) disable iff (i_rst)
      i_op.fast_return_from_interrupt_instr || i_op.fast_ret |=> o_ctx_restore_valid && o_ctx_restore == $past(shadow_q);
  endproperty
  a_restore: assert property (p_restore) else $error("restore mismatch");

  property p_slow_keep;
    @(posedge i_mclk) disable iff (i_rst)
      (i_op.slow_call || i_op.slow_ret || i_op.slow_return_from_interrupt_instr) && !i_op.int_vector
      && !i_op.fast_call && !i_op.fast_ret && !i_op.fast_return_from_interrupt_instr
      |=> $stable(shadow_q) && !o_ctx_restore_valid;
  endproperty
  a_slow_keep: assert property (p_slow_keep) else $error("slow op touched context");

  property p_literal;
    @(posedge i_mclk) disable iff (i_rst)
      i_op.ret_literal |=> o_working_load_valid && o_working_load == $past(i_literal);
  endproperty
  a_literal: assert property (p_literal) else $error("literal not loaded");

  property p_jump;
    @(posedge i_mclk) disable iff (i_rst)
      i_op.add_pcl |=> o_pc_jump_valid &&
      o_pc_jump == $past(i_program_counter) + $past(i_ctx.working);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_unf_set;
    @(posedge i_mclk) disable iff (i_rst) i_stack_underflow_evt |=> o_stack_underflow_flag;
  endproperty
  a_unf_set: assert property (p_unf_set) else $error("underflow flag not set");

  property p_full_hold;
    @(posedge i_mclk) disable iff (i_rst)
      o_stack_full_flag && !i_flag_wr |=> o_stack_full_flag;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full flag lost");

  property p_full_write;
    @(posedge i_mclk) disable iff (i_rst)
      i_flag_wr && !i_stack_full_evt |=> o_stack_full_flag == $past(i_stack_full_wr_val);
  endproperty
  a_full_write: assert property (p_full_write) else $error("full flag write lost");

  property p_unf_write;
    @(posedge i_mclk) disable iff (i_rst)
      i_flag_wr && !i_stack_underflow_evt |=>
      o_stack_underflow_flag == $past(i_stack_underflow_wr_val);
  endproperty
  a_unf_write: assert property (p_unf_write) else $error("underflow flag write lost");

  property p_reset_quiet;
    @(posedge i_mclk) disable iff (i_rst)
      !i_stack_full_evt && !i_stack_underflow_evt |=> ##1 !o_device_reset;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset without fault");

  property p_shadow_hold;
    @(posedge i_mclk) disable iff (i_rst)
      !i_op.int_vector && !i_op.fast_call |=> $stable(shadow_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed unasked");

  property p_restore_quiet;
    @(posedge i_mclk) disable iff (i_rst)
      !i_op.fast_ret && !i_op.fast_return_from_interrupt_instr |=> !o_ctx_restore_valid;
  endproperty
  a_restore_quiet: assert property (p_restore_quiet) else $error("restore unasked");

  property p_jump_quiet;
    @(posedge i_mclk) disable iff (i_rst)
      !i_op.add_pcl |=> !o_pc_jump_valid;
  endproperty
  a_jump_quiet: assert property (p_jump_quiet) else $error("jump unasked");
endmodule : sfc_core
`default_nettype wire

// File: verilog/sfc_pkg.sv
// package: shared constants and carrier types for the stack fault and fast context block
package sfc_pkg;
  localparam int unsigned PC_W = 21;
  localparam int unsigned TP_W = 22;
  localparam int unsigned DATA_W = 8;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam int unsigned BYTE_SEL_BIT = 0;

  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] working;
    logic [DATA_W-1:0] bank;
  } sfc_ctx_t;

  localparam sfc_ctx_t CTX_RESET = '{status: 8'h00, working: 8'h00, bank: 8'h00};

  typedef struct packed {
    logic int_vector;
    logic fast_call;
    logic fast_ret;
    logic fast_return_from_interrupt_instr;
    logic slow_call;
    logic slow_ret;
    logic slow_return_from_interrupt_instr;
    logic ret_literal;
    logic add_pcl;
    logic tbl_read;
  } sfc_op_t;

  typedef enum logic [1:0] {
    SFC_TBL_IDLE,
    SFC_TBL_FETCH
  } sfc_tbl_state_t;
endpackage : sfc_pkg

// File: verilog/sfc_table_reader.sv
// module: byte-wise table read from 16-bit program memory words
`timescale 1ns/10ps
`default_nettype none
module sfc_table_reader (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [sfc_pkg::TP_W-1:0] i_table_pointer,
  output logic [sfc_pkg::TP_W-2:0] o_word_addr,
  output logic o_word_req,
  input wire logic [15:0] i_word_data,
  output logic [sfc_pkg::DATA_W-1:0] o_table_latch,
  output logic o_done
);
  sfc_pkg::sfc_tbl_state_t state_q;
  logic hi_sel_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= sfc_pkg::SFC_TBL_IDLE;
      hi_sel_q <= 1'b0;
      o_word_addr <= '0;
      o_table_latch <= sfc_pkg::BYTE_ZERO;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        sfc_pkg::SFC_TBL_IDLE: begin
          if (i_start) begin
            o_word_addr <= i_table_pointer[sfc_pkg::TP_W-1:sfc_pkg::BYTE_SEL_BIT+1];
            hi_sel_q <= i_table_pointer[sfc_pkg::BYTE_SEL_BIT];
            state_q <= sfc_pkg::SFC_TBL_FETCH;
          end
        end
        sfc_pkg::SFC_TBL_FETCH: begin
          o_table_latch <= hi_sel_q ? i_word_data[15:8] : i_word_data[7:0];
          o_done <= 1'b1;
          state_q <= sfc_pkg::SFC_TBL_IDLE;
        end
        default: state_q <= sfc_pkg::SFC_TBL_IDLE;
      endcase
    end
  end

  assign o_word_req = (state_q == sfc_pkg::SFC_TBL_FETCH);

  sequence s_fetch_done;
    o_word_req ##1 o_done ##1 !o_done;
  endsequence

  property p_one_byte;
    @(posedge i_mclk) disable iff (i_rst)
      i_start && state_q == sfc_pkg::SFC_TBL_IDLE |=> s_fetch_done;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("table read not done in two cycles");
endmodule : sfc_table_reader
`default_nettype wire

// File: tb/sfc_prog_mem.sv
// program memory model answering word fetches of the table reader
`timescale 1ns/10ps
`default_nettype none
module sfc_prog_mem (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [sfc_pkg::TP_W-2:0] i_word_addr,
  input wire logic i_word_req,
  output logic [15:0] o_word_data
);
  logic [15:0] last_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      last_q <= 16'h0000;
    end else if (i_word_req) begin
      last_q <= o_word_data;
    end
  end
  // high byte differs from low byte so a swapped pick shows
  always_comb begin
    o_word_data = i_word_req ? {~i_word_addr[7:0], i_word_addr[7:0]} : ~last_q;
  end
endmodule : sfc_prog_mem
`default_nettype wire

// File: tb/stack_fault_and_fast_context_test.sv
// self-checking bench for the stack fault and fast context core
`timescale 1ns/10ps
`default_nettype none
`define SFC_CHK(n, e, a) check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end
module stack_fault_and_fast_context_test;
  logic mclk, rst, por, en, full, unf, fwr, full_f, unf_f, dev_rst, rv, wlv, jv, wreq, done;
  sfc_pkg::sfc_op_t op;
  sfc_pkg::sfc_ctx_t ctx, rest;
  logic [7:0] lit, wl, latch;
  logic [20:0] pc, jmp, waddr;
  logic [21:0] tp;
  logic [15:0] wdata;
  int n_fail = 0;
  int check_count = 0;
  always #5 mclk = ~mclk;
  sfc_core u_sfc_core (.i_mclk(mclk), .i_rst(rst), .i_por(por),
    .i_stack_fault_reset_enable(en), .i_stack_full_evt(full), .i_stack_underflow_evt(unf),
    .i_flag_wr(fwr), .i_stack_full_wr_val(1'b0), .i_stack_underflow_wr_val(1'b0),
    .i_op(op), .i_ctx(ctx), .i_literal(lit), .i_program_counter(pc), .i_table_pointer(tp),
    .i_word_data(wdata), .o_stack_full_flag(full_f), .o_stack_underflow_flag(unf_f),
    .o_device_reset(dev_rst), .o_ctx_restore(rest), .o_ctx_restore_valid(rv),
    .o_working_load(wl), .o_working_load_valid(wlv), .o_pc_jump(jmp), .o_pc_jump_valid(jv),
    .o_word_addr(waddr), .o_word_req(wreq), .o_table_latch(latch), .o_table_done(done));
  sfc_prog_mem u_sfc_prog_mem (.i_mclk(mclk), .i_rst(rst), .i_word_addr(waddr),
    .i_word_req(wreq), .o_word_data(wdata));
  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic fire(input logic [9:0] o, input logic [23:0] c);
    @(posedge mclk) begin op <= o; ctx <= c; end
    @(posedge mclk) op <= '0;
    #1;
  endtask : fire
  task automatic chk_rest(input logic v, input logic [23:0] c);
    `SFC_CHK("restore_valid", v, rv)
    if (v) begin `SFC_CHK("restore", c, rest) end
  endtask : chk_rest
  task automatic t_fault;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) begin en <= k[1]; full <= !k[0]; unf <= k[0]; end
      @(posedge mclk) begin full <= 1'b0; unf <= 1'b0; end
      #1 `SFC_CHK("fault_flag", 1'b1, k[0] ? unf_f : full_f)
      `SFC_CHK("reset_early", 1'b0, dev_rst)
      @(posedge mclk) #1 `SFC_CHK("device_reset", 1'(k[1]), dev_rst)
      @(posedge mclk) rst <= 1'b1;
      @(posedge mclk) rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1 `SFC_CHK("flag_kept", 1'b1, k[0] ? unf_f : full_f)
      @(posedge mclk) fwr <= 1'b1;
      @(posedge mclk) fwr <= 1'b0;
      #1 `SFC_CHK("flag_cleared", 1'b0, k[0] ? unf_f : full_f)
    end
  endtask : t_fault
  task automatic t_por;
    @(posedge mclk) begin full <= 1'b1; fwr <= 1'b1; end
    @(posedge mclk) begin full <= 1'b0; fwr <= 1'b0; end
    #1 `SFC_CHK("set_wins", 1'b1, full_f)
    @(posedge mclk) begin rst <= 1'b1; por <= 1'b1; end
    @(posedge mclk) begin rst <= 1'b0; por <= 1'b0; end
    #1 `SFC_CHK("por_clear", 1'b0, full_f)
  endtask : t_por
  task automatic t_ctx;
    fire(10'h200, 24'h112233);
    for (int k = 0; k < 3; k++) begin
      fire(10'h020 >> k, 24'h445566);
      chk_rest(1'b0, 24'h0);
    end
    fire(10'h040, 24'h778899);
    chk_rest(1'b1, 24'h112233);
    fire(10'h200, 24'ha1b2c3);
    fire(10'h200, 24'hd4e5f6);
    fire(10'h080, 24'h000000);
    chk_rest(1'b1, 24'hd4e5f6);
    fire(10'h100, 24'h0a0b0c);
    fire(10'h080, 24'hffffff);
    chk_rest(1'b1, 24'h0a0b0c);
  endtask : t_ctx
  task automatic t_jump;
    @(posedge mclk) begin pc <= 21'h0001fa; lit <= 8'h5c; end
    fire(10'h002, 24'h000600);
    `SFC_CHK("jump_valid", 1'b1, jv)
    `SFC_CHK("jump", 21'h000200, jmp)
    fire(10'h004, 24'h000000);
    `SFC_CHK("literal_valid", 1'b1, wlv)
    `SFC_CHK("literal", 8'h5c, wl)
  endtask : t_jump
  task automatic t_table(input logic [21:0] p);
    @(posedge mclk) tp <= p;
    fire(10'h001, 24'h0);
    `SFC_CHK("word_req", 1'b1, wreq)
    `SFC_CHK("word_addr", p[21:1], waddr)
    @(posedge mclk) #1 `SFC_CHK("table_done", 1'b1, done)
    `SFC_CHK("table_latch", p[0] ? ~p[8:1] : p[8:1], latch)
    `SFC_CHK("word_req_end", 1'b0, wreq)
  endtask : t_table
  initial begin
    mclk = 1'b0; rst = 1'b1; por = 1'b1; en = 1'b0; full = 1'b0; unf = 1'b0; fwr = 1'b0;
    op = '0; ctx = '0; lit = 8'h00; pc = 21'h000000; tp = 22'h000000;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge mclk) #1;
    t_fault;
    t_por;
    t_ctx;
    t_jump;
    t_table(22'h000246);
    t_table(22'h000247);
    t_table(22'h3fffff);
    conclude;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    conclude;
  end
endmodule : stack_fault_and_fast_context_test
`default_nettype wire
